// ==== hw/fpb_map.svh ====
/*
  timing counts and field positions for the flash parallel bus host controller.
  assumes a 100 MHz controller clock; included by bare name.
*/
`ifndef FPB_MAP_SVH
`define FPB_MAP_SVH
`define FPB_CLK_PERIOD_NS 10
`define FPB_ADDR_W 17
`define FPB_DATA_W 16
`define FPB_BYTE_W 8
`define FPB_ID_LINE_BIT 9
`define FPB_WORD_ADDR_BIT 0
`define FPB_TOP_DQ_BIT 15
`define FPB_SETUP_NS 60
`define FPB_SETUP_CYC ((`FPB_SETUP_NS + `FPB_CLK_PERIOD_NS - 1) / `FPB_CLK_PERIOD_NS)
`define FPB_PULSE_NS 60
`define FPB_PULSE_CYC ((`FPB_PULSE_NS + `FPB_CLK_PERIOD_NS - 1) / `FPB_CLK_PERIOD_NS)
`define FPB_HOLD_NS 20
`define FPB_HOLD_CYC ((`FPB_HOLD_NS + `FPB_CLK_PERIOD_NS - 1) / `FPB_CLK_PERIOD_NS)
`define FPB_WAKE_NS 300
`define FPB_WAKE_CYC ((`FPB_WAKE_NS + `FPB_CLK_PERIOD_NS - 1) / `FPB_CLK_PERIOD_NS)
`define FPB_CNT_W 6
`define FPB_PROG_CMD 16'h0040
`define FPB_READ_ARRAY_CMD 16'h00ff
`endif

// ==== hw/fpb_pkg.sv ====
/*
  types for the flash parallel bus host controller.
  assumes the constants header is compiled alongside.
*/
package fpb_pkg;
  typedef enum logic [2:0] {
    FPB_IDLE = 3'b000,
    FPB_SETUP = 3'b001,
    FPB_PULSE = 3'b011,
    FPB_HOLD = 3'b010,
    FPB_DONE = 3'b110,
    FPB_WAKE = 3'b100
  } fpb_state_type;
  typedef enum logic [1:0] {
    FPB_OP_READ = 2'h0,
    FPB_OP_WRITE = 2'h1,
    FPB_OP_PROGRAM = 2'h2,
    FPB_OP_IDREAD = 2'h3
  } fpb_op_type;
endpackage : fpb_pkg

// ==== hw/fpb_sync.sv ====
/*
  two-flop synchroniser for the data pins coming back from the flash.
  assumes the input is asynchronous to i_ref_clk.
*/
`timescale 1ns/1ns
module fpb_sync (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [15:0] i_async,
  output logic [15:0] o_sync
);
  logic [15:0] meta_r;
  // first stage feeds only the second stage
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= 16'h0000;
      o_sync <= 16'h0000;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : fpb_sync

// ==== hw/fpb_host.sv ====
/*
  host-side controller that drives a boot-block flash over its parallel pins:
  chip/write/output enables, address, byte select, reset/power-down, id-line
  high-voltage request and two-way data pins.
  assumes a single 100 MHz clock; the high-voltage switch on the id line is
  external logic steered by o_id_hv_en.
*/
`timescale 1ns/1ns
`include "fpb_map.svh"
// Functional notes
// - host raises id line to high voltage to read signature codes.
// - program data supplied on second write cycle of program command.
// - commands sent on low lanes with chip and write enable low.
// - byte mode top data pin is least significant address; id reads in byte mode leave it undriven.
// - address and data held stable around write-enable rising edge.
module fpb_host
  import fpb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [1:0] i_req_op,
  input wire logic [17:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  input wire logic i_byte_mode,
  input wire logic i_powerdown,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_rdata,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic o_byte_mode_n,
  output logic o_reset_powerdown_n,
  output logic o_id_hv_en,
  output logic [16:0] o_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe
);
  fpb_state_type state_r, state_nxt;
  fpb_op_type op_r;
  logic second_r;
  logic byte_r;
  logic [17:0] addr_r;
  logic [15:0] wdata_r;
  logic [`FPB_CNT_W-1:0] cnt_r;
  logic [15:0] dq_sync;
  logic is_write;
  logic cnt_zero;
  logic pd_r;

  fpb_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_dq),
    .o_sync(dq_sync)
  );

  assign is_write = (op_r == FPB_OP_WRITE) || (op_r == FPB_OP_PROGRAM);
  assign cnt_zero = (cnt_r == '0);
  assign o_req_ready = (state_r == FPB_IDLE) && !i_powerdown && !pd_r;

  // next-state; program op runs two write cycles, command then data
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FPB_IDLE: if (i_req_valid && o_req_ready) state_nxt = FPB_SETUP;
      FPB_SETUP: if (cnt_zero) state_nxt = FPB_PULSE;
      FPB_PULSE: if (cnt_zero) state_nxt = FPB_HOLD;
      FPB_HOLD: begin
        if (cnt_zero) state_nxt = (op_r == FPB_OP_PROGRAM && !second_r) ? FPB_SETUP : FPB_DONE;
      end
      FPB_DONE: state_nxt = FPB_IDLE;
      FPB_WAKE: if (cnt_zero) state_nxt = FPB_IDLE;
      default: state_nxt = FPB_IDLE;
    endcase
  end

  // state register; power-down entry wins over any cycle in flight
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) state_r <= FPB_IDLE;
    else if (i_powerdown) state_r <= FPB_IDLE;
    else if (pd_r) state_r <= FPB_WAKE;
    else state_r <= state_nxt;
  end

  // reset/power-down pin; rising edge puts the flash back in read-array
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) pd_r <= 1'b1;
    else pd_r <= i_powerdown;
  end
  assign o_reset_powerdown_n = !pd_r;

  // phase counter, loaded on each phase change
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) cnt_r <= '0;
    else if (pd_r) cnt_r <= `FPB_CNT_W'(`FPB_WAKE_CYC - 1);
    else if (state_r != state_nxt) begin
      case (state_nxt)
        FPB_SETUP: cnt_r <= `FPB_CNT_W'(`FPB_SETUP_CYC - 1);
        FPB_PULSE: cnt_r <= `FPB_CNT_W'(`FPB_PULSE_CYC - 1);
        FPB_HOLD: cnt_r <= `FPB_CNT_W'(`FPB_HOLD_CYC - 1);
        default: cnt_r <= '0;
      endcase
    end else if (!cnt_zero) cnt_r <= cnt_r - 1'b1;
  end

  // request capture; byte mode is frozen per transfer
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_r <= FPB_OP_READ;
      addr_r <= 18'h0_0000;
      wdata_r <= 16'h0000;
      byte_r <= 1'b0;
      second_r <= 1'b0;
    end else if (state_r == FPB_IDLE && i_req_valid && o_req_ready) begin
      op_r <= fpb_op_type'(i_req_op);
      addr_r <= i_req_addr;
      wdata_r <= i_req_wdata;
      byte_r <= i_byte_mode;
      second_r <= 1'b0;
    end else if (state_r == FPB_HOLD && cnt_zero) second_r <= 1'b1;
  end

  // pin strobes; write enable rises at the end of pulse with address/data still held
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ce_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
    end else begin
      o_ce_n <= !(state_nxt == FPB_SETUP || state_nxt == FPB_PULSE || state_nxt == FPB_HOLD) || i_powerdown;
      o_we_n <= !(state_nxt == FPB_PULSE && is_write) || i_powerdown;
      o_oe_n <= !((state_nxt == FPB_PULSE || state_nxt == FPB_HOLD) && !is_write) || i_powerdown;
    end
  end

  // address, byte select and id-line high voltage; held through hold phase
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_addr <= 17'h0_0000;
      o_byte_mode_n <= 1'b1;
      o_id_hv_en <= 1'b0;
    end else if (state_r == FPB_SETUP) begin
      o_addr <= addr_r[17:1];
      o_byte_mode_n <= !byte_r;
      o_id_hv_en <= (op_r == FPB_OP_IDREAD);
      if (op_r == FPB_OP_IDREAD) o_addr[`FPB_ID_LINE_BIT] <= 1'b0;
    end else if (state_r == FPB_DONE || state_r == FPB_IDLE) begin
      o_id_hv_en <= 1'b0;
    end
  end

  // data drive; byte mode puts byte address on the top pin except on id reads, upper lanes released
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dq <= 16'h0000;
      o_dq_oe <= 16'h0000;
    end else if (state_r == FPB_SETUP && is_write) begin
      o_dq <= (op_r == FPB_OP_PROGRAM && !second_r) ? `FPB_PROG_CMD : wdata_r;
      o_dq_oe <= byte_r ? 16'h00ff : 16'hffff;
      if (byte_r) o_dq[`FPB_TOP_DQ_BIT] <= addr_r[0];
      if (byte_r) o_dq_oe[`FPB_TOP_DQ_BIT] <= 1'b1;
    end else if (state_r == FPB_SETUP && byte_r && op_r != FPB_OP_IDREAD) begin
      o_dq <= {addr_r[0], 15'h0000};
      o_dq_oe <= 16'h8000;
    end else if (state_r == FPB_SETUP) begin
      o_dq_oe <= 16'h0000;
    end else if (state_r == FPB_DONE || state_r == FPB_IDLE) begin
      o_dq_oe <= 16'h0000;
    end
  end

  // read data capture; upper lanes dropped for byte or id reads
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= 16'h0000;
    end else begin
      o_rsp_valid <= (state_r == FPB_DONE);
      if (state_r == FPB_HOLD && cnt_zero && !is_write) begin
        if (byte_r || op_r == FPB_OP_IDREAD) o_rsp_rdata <= {8'h00, dq_sync[7:0]};
        else o_rsp_rdata <= dq_sync;
      end
    end
  end

  // pin protocol checks on the controller clock; quiet while reset is held
  // write pulse lasts the full pulse phase, six cycles at 100 MHz
  property p_we_pulse_len;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    $fell(o_we_n) |-> !o_we_n [*6];
  endproperty
  a_we_pulse_len: assert property (p_we_pulse_len) else $error("write pulse too short");

  // address and data must not move during the pulse or at its rising edge
  property p_we_hold;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !o_we_n |=> $stable(o_addr) && $stable(o_dq) && $stable(o_dq_oe);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("address or data moved around write pulse");

  // while the flash drives, the host releases the data lanes; only the byte address pin stays
  property p_oe_bus_free;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !o_oe_n |-> (o_dq_oe == 16'h0000) || ((o_dq_oe == 16'h8000) && !o_byte_mode_n);
  endproperty
  a_oe_bus_free: assert property (p_oe_bus_free) else $error("host drives data lanes during read");

  // a strobe outside chip enable would be ignored by the flash
  property p_strobe_in_ce;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!o_we_n || !o_oe_n) |-> !o_ce_n;
  endproperty
  a_strobe_in_ce: assert property (p_strobe_in_ce) else $error("strobe without chip enable");

  // id line back to logic levels in the same cycle the answer is handed over
  property p_hv_off_at_rsp;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_rsp_valid |-> !o_id_hv_en;
  endproperty
  a_hv_off_at_rsp: assert property (p_hv_off_at_rsp) else $error("id line still high at answer");

  // no strobes while the flash sits in power-down
  property p_pd_quiet;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !o_reset_powerdown_n |-> o_ce_n && o_we_n && o_oe_n;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("strobe during power-down");

  // main scenarios reached
  property p_cov_byte_write;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(o_we_n) && !o_byte_mode_n;
  endproperty
  c_byte_write: cover property (p_cov_byte_write);
  property p_cov_id_read;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(o_oe_n) && o_id_hv_en;
  endproperty
  c_id_read: cover property (p_cov_id_read);
  property p_cov_byte_read_hi;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !o_oe_n && !o_byte_mode_n && o_dq[15] && o_dq_oe[15];
  endproperty
  c_byte_read_hi: cover property (p_cov_byte_read_hi);
  property p_cov_wake;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(o_reset_powerdown_n);
  endproperty
  c_wake: cover property (p_cov_wake);
endmodule : fpb_host

// ==== test/fpb_flash_model.sv ====
/*
  flash pin model: array, program command, signature codes; returns resolved dq level.
  assumes the host drives the control pins; undriven lanes show the inverse of their last level.
*/
`timescale 1ns/1ns
`include "fpb_map.svh"
module fpb_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00a5, // arbitrary
  parameter logic [15:0] DEV_CODE = 16'h005c // arbitrary
) (
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_byte_mode_n,
  input wire logic i_reset_powerdown_n,
  input wire logic i_id_hv_en,
  input wire logic [16:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic [15:0] i_dq_oe,
  output logic [15:0] o_wire
);
  logic [7:0] mem [logic [17:0]];
  logic prog_r = 1'b0;
  logic [15:0] rd, en, last_r = 16'h0000;
  // address and data taken at the write-enable rise; power-down drops any half-sent command
  always @(posedge i_we_n or negedge i_reset_powerdown_n) begin
    if (!i_reset_powerdown_n) prog_r = 1'b0;
    else if (!i_ce_n) begin
      if (prog_r && !i_byte_mode_n) mem[{i_addr, i_dq[15]}] = i_dq[7:0];
      else if (prog_r) begin
        mem[{i_addr, 1'b0}] = i_dq[7:0];
        mem[{i_addr, 1'b1}] = i_dq[15:8];
      end
      prog_r = !prog_r && ({8'h00, i_dq[7:0]} == `FPB_PROG_CMD);
    end
  end
  // read lanes by mode
  always @* begin
    en = 16'h0000;
    rd = 16'h0000;
    if (!i_ce_n && !i_oe_n && i_we_n && i_reset_powerdown_n) begin
      en = i_byte_mode_n ? 16'hffff : 16'h00ff;
      if (i_id_hv_en) begin
        rd = {8'h00, i_addr[0] ? DEV_CODE[7:0] : MFR_CODE[7:0]};
        en = 16'h00ff;
      end else if (!i_byte_mode_n) rd = {8'h00, mem[{i_addr, i_dq[15]}]};
      else rd = {mem[{i_addr, 1'b1}], mem[{i_addr, 1'b0}]};
    end
  end
  // edge-sampled so a floating lane cannot oscillate
  always @(posedge i_oe_n or posedge i_we_n) last_r = o_wire;
  always @* begin
    for (int b = 0; b < 16; b++) o_wire[b] = i_dq_oe[b] ? i_dq[b] : en[b] ? rd[b] : ~last_r[b];
  end
endmodule : fpb_flash_model

// ==== test/tb_fpb_host.sv ====
/*
  bench for the flash host: random program and readback in both lane modes, signature reads, wake.
  assumes the pin model answers on the far side and i_byte_mode high selects byte lanes.
*/
`timescale 1ns/1ns
`include "fpb_map.svh"
module tb_fpb_host import fpb_pkg::*; ;
  localparam logic [15:0] ID_MFR = 16'h00a5; // arbitrary
  localparam logic [15:0] ID_DEV = 16'h005c; // arbitrary
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, byte_mode = 1'b0, powerdown = 1'b1;
  logic [1:0] req_op = 2'h0;
  logic [17:0] req_addr = 18'h0_0000;
  logic [15:0] req_wdata = 16'h0000, rsp, wire_dq, dq, dq_oe, rdata;
  logic req_ready, rsp_valid, ce_n, we_n, oe_n, bm_n, rp_n, hv;
  logic [16:0] addr;
  logic [15:0] lfsr = 16'h5f8a;
  logic [15:0] ref_w [logic [17:0]];
  logic [7:0] ref_b [logic [17:0]];
  logic [17:0] wa [$], ba [$];
  int n_fail = 0, checked = 0;
  always #5 clk = ~clk;
  fpb_host dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_req_valid(req_valid), .o_req_ready(req_ready),
    .i_req_op(req_op), .i_req_addr(req_addr), .i_req_wdata(req_wdata), .i_byte_mode(byte_mode),
    .i_powerdown(powerdown), .o_rsp_valid(rsp_valid), .o_rsp_rdata(rdata), .o_ce_n(ce_n), .o_we_n(we_n),
    .o_oe_n(oe_n), .o_byte_mode_n(bm_n), .o_reset_powerdown_n(rp_n), .o_id_hv_en(hv), .o_addr(addr),
    .i_dq(wire_dq), .o_dq(dq), .o_dq_oe(dq_oe));
  fpb_flash_model #(.MFR_CODE(ID_MFR), .DEV_CODE(ID_DEV)) dev (.i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_byte_mode_n(bm_n), .i_reset_powerdown_n(rp_n), .i_id_hv_en(hv), .i_addr(addr), .i_dq(dq),
    .i_dq_oe(dq_oe), .o_wire(wire_dq));
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : rnd
  // request held until taken, then bounded wait for the answer pulse
  task automatic req(fpb_op_type op, logic [17:0] a, logic [15:0] d, logic bm);
    int t;
    @(negedge clk);
    {req_op, req_addr, req_wdata, byte_mode, req_valid} = {op, a, d, bm, 1'b1};
    t = 0;
    while (req_ready !== 1'b1 && t++ < 200) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && t++ < 400) @(negedge clk);
    rsp = rdata;
    if (t >= 400) n_fail++;
    @(negedge clk);
    cmp("dq_oe", 16'h0000, dq_oe);
  endtask : req
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    cmp("rp_n", 16'h0000, {15'h0000, rp_n});
    powerdown = 1'b0;
    req(FPB_OP_WRITE, 18'h0_0000, `FPB_READ_ARRAY_CMD, 1'b0);
    for (int i = 0; i < 6; i++) begin
      lfsr = rnd(lfsr);
      wa.push_back({6'h00, 3'(i), lfsr[7:0], 1'b0});
      ba.push_back({2'b11, 3'(i), lfsr[11:0], 1'b0});
      ref_w[wa[i]] = rnd(lfsr);
      req(FPB_OP_PROGRAM, wa[i], ref_w[wa[i]], 1'b0);
      for (int b = 0; b < 2; b++) begin
        ref_b[ba[i] | 18'(b)] = b ? lfsr[7:0] : lfsr[15:8];
        req(FPB_OP_PROGRAM, ba[i] | 18'(b), {8'h00, ref_b[ba[i] | 18'(b)]}, 1'b1);
      end
    end
    foreach (wa[i]) begin
      req(FPB_OP_READ, wa[i], 16'h0000, 1'b0);
      cmp("word", ref_w[wa[i]], rsp);
      for (int b = 0; b < 2; b++) begin
        req(FPB_OP_READ, ba[i] | 18'(b), 16'h0000, 1'b1);
        cmp("byte", {8'h00, ref_b[ba[i] | 18'(b)]}, rsp);
      end
    end
    for (int i = 0; i < 8; i++) begin
      req(FPB_OP_IDREAD, 18'(i), 16'h0000, i[2]);
      cmp("id", i[1] ? ID_DEV : ID_MFR, rsp);
    end
    req(FPB_OP_READ, wa[0], 16'h0000, 1'b0);
    cmp("after_id", ref_w[wa[0]], rsp);
    req(FPB_OP_WRITE, 18'h0_0000, `FPB_PROG_CMD, 1'b0);
    powerdown = 1'b1;
    repeat (5) @(negedge clk);
    cmp("rp_n", 16'h0000, {15'h0000, rp_n});
    powerdown = 1'b0;
    ref_w[wa[1]] = ~ref_w[wa[1]];
    req(FPB_OP_PROGRAM, wa[1], ref_w[wa[1]], 1'b0);
    req(FPB_OP_READ, wa[1], 16'h0000, 1'b0);
    cmp("wake", ref_w[wa[1]], rsp);
    finish_test();
  end
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule : tb_fpb_host
